// ===== rtl/secl_loader.sv
`timescale 1ns/1ns
`include "secl_regs.svh"
module secl_loader
  import secl_pkg::*;
#(
  parameter int WORDS  = 8,
  parameter int ADDR_W = 6,
  parameter bit IS_32B = 1'b0
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // Straps and on-chip speed setting
  input  wire logic              prom_present_strap_i,
  input  wire logic [1:0]        onchip_bus_speed_ctl_i,
  // Serial EEPROM link
  input  wire logic              prom_serial_in_width_strap_i,
  output logic                   prom_serial_out_o,
  output logic                   prom_serial_clock_o,
  output logic                   prom_cs_o,
  // Loaded configuration
  output logic [15:0]            cfg_word_o,
  output logic [ADDR_W-1:0]      cfg_addr_o,
  output logic                   cfg_we_o,
  output logic                   config_done_o,
  output secl_bus_e              bus_mode_o
);

  //----------------------------------------------------------------
  // Constants
  //----------------------------------------------------------------
  localparam logic [5:0] HALF_SLOW = 6'(`SECL_HALF_SLOW);
  localparam logic [5:0] HALF_FAST = 6'(`SECL_HALF_FAST);
  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(WORDS - 1);

  //----------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------
  logic [1:0] pins_sync;

  secl_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i ({prom_present_strap_i, prom_serial_in_width_strap_i}),
    .sync_o  (pins_sync)
  );

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  secl_state_e       state_reg,   state_next;
  logic [1:0]        settle_reg,  settle_next;
  logic              present_reg, present_next;
  logic              slow_reg,    slow_next;
  logic [5:0]        div_reg,     div_next;
  logic [4:0]        bit_reg,     bit_next;
  logic [15:0]       shift_reg,   shift_next;
  logic [ADDR_W-1:0] rdaddr_reg,  rdaddr_next;
  logic              sk_reg,      sk_next;
  logic              dout_reg,    dout_next;
  logic              cs_reg,      cs_next;
  logic [15:0]       word_reg,    word_next;
  logic [ADDR_W-1:0] waddr_reg,   waddr_next;
  logic              we_reg,      we_next;
  logic              done_reg,    done_next;
  secl_bus_e         mode_reg,    mode_next;

  logic [5:0]                    half_max;
  logic [`SECL_CMD_BITS-1:0]     cmd_word;

  // Last divider count of a serial clock half period (half period minus one), fixed by the latched speed
  assign half_max = (slow_reg ? HALF_SLOW : HALF_FAST) - 6'h01;
  // Start bit and read opcode, then the word address
  assign cmd_word = {`SECL_READ_OP, rdaddr_reg};

  // Next-state logic for the whole loader
  always_comb begin
    state_next   = state_reg;
    settle_next  = settle_reg;
    present_next = present_reg;
    slow_next    = slow_reg;
    div_next     = div_reg;
    bit_next     = bit_reg;
    shift_next   = shift_reg;
    rdaddr_next  = rdaddr_reg;
    sk_next      = sk_reg;
    dout_next    = dout_reg;
    cs_next      = cs_reg;
    word_next    = word_reg;
    waddr_next   = waddr_reg;
    we_next      = 1'b0;
    done_next    = done_reg;
    mode_next    = mode_reg;
    case (state_reg)
      SECL_SAMPLE: begin
        // Wait for the synchroniser to flush, then latch the straps once
        if (settle_reg != 2'(`SECL_SETTLE_CYC)) begin
          settle_next = settle_reg + 2'h1;
        end else begin
          present_next = pins_sync[1];
          // Speeds between the two documented ones use the safe slow clock
          slow_next = (onchip_bus_speed_ctl_i != `SECL_SPEED_FAST);
          if (IS_32B) begin
            mode_next = SECL_BUS_32;
          end else if (!pins_sync[1]) begin
            mode_next = pins_sync[0] ? SECL_BUS_16 : SECL_BUS_8;
          end
          div_next   = 6'h00;
          state_next = pins_sync[1] ? SECL_GAP : SECL_DONE;
        end
      end
      SECL_GAP: begin
        // Chip select stays low for one half period between reads
        if (div_reg == half_max) begin
          div_next   = 6'h00;
          bit_next   = 5'h00;
          cs_next    = 1'b1;
          sk_next    = 1'b0;
          dout_next  = cmd_word[`SECL_CMD_BITS-1];
          state_next = SECL_SHIFT;
        end else begin
          div_next = div_reg + 6'h01;
        end
      end
      SECL_SHIFT: begin
        if (div_reg != half_max) begin
          div_next = div_reg + 6'h01;
        end else if (!sk_reg) begin
          div_next = 6'h00;
          sk_next  = 1'b1;
        end else begin
          div_next = 6'h00;
          sk_next  = 1'b0;
          // Sample late in the high phase so the EEPROM output has settled
          if (bit_reg >= 5'(`SECL_FIRST_DATA)) begin
            shift_next = {shift_reg[14:0], pins_sync[0]};
          end
          if (bit_reg == 5'(`SECL_LAST_BIT)) begin
            word_next   = {shift_reg[14:0], pins_sync[0]};
            waddr_next  = rdaddr_reg;
            we_next     = 1'b1;
            cs_next     = 1'b0;
            dout_next   = 1'b0;
            rdaddr_next = rdaddr_reg + ADDR_W'(1);
            state_next  = (rdaddr_reg == LAST_ADDR) ? SECL_DONE : SECL_GAP;
          end else begin
            bit_next = bit_reg + 5'h01;
            // Command bits go out while the clock is low; zero afterwards
            if (bit_reg < 5'(`SECL_CMD_BITS - 1)) begin
              dout_next = cmd_word[4'(`SECL_CMD_BITS - 2) - bit_reg[3:0]];
            end else begin
              dout_next = 1'b0;
            end
          end
        end
      end
      SECL_DONE: begin
        done_next = 1'b1;
      end
      default: begin
        state_next = SECL_SAMPLE;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg   <= SECL_SAMPLE;
      settle_reg  <= 2'h0;
      present_reg <= 1'b0;
      slow_reg    <= 1'b1;
      div_reg     <= 6'h00;
      bit_reg     <= 5'h00;
      shift_reg   <= 16'h0000;
      rdaddr_reg  <= '0;
      sk_reg      <= 1'b0;
      dout_reg    <= 1'b0;
      cs_reg      <= 1'b0;
      word_reg    <= 16'h0000;
      waddr_reg   <= '0;
      we_reg      <= 1'b0;
      done_reg    <= 1'b0;
      mode_reg    <= SECL_BUS_8;
    end else begin
      state_reg   <= state_next;
      settle_reg  <= settle_next;
      present_reg <= present_next;
      slow_reg    <= slow_next;
      div_reg     <= div_next;
      bit_reg     <= bit_next;
      shift_reg   <= shift_next;
      rdaddr_reg  <= rdaddr_next;
      sk_reg      <= sk_next;
      dout_reg    <= dout_next;
      cs_reg      <= cs_next;
      word_reg    <= word_next;
      waddr_reg   <= waddr_next;
      we_reg      <= we_next;
      done_reg    <= done_next;
      mode_reg    <= mode_next;
    end
  end

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  assign prom_serial_out_o   = dout_reg;
  assign prom_serial_clock_o = sk_reg;
  assign prom_cs_o           = cs_reg;
  assign cfg_word_o          = word_reg;
  assign cfg_addr_o          = waddr_reg;
  assign cfg_we_o            = we_reg;
  assign config_done_o       = done_reg;
  assign bus_mode_o          = mode_reg;

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  // Cycles since the serial clock last changed level
  logic [6:0] sk_age_reg;
  always_ff @(posedge mclk_i) begin
    if (rst_i || (sk_reg != $past(sk_reg))) begin
      sk_age_reg <= 7'h00;
    end else if (sk_age_reg != 7'h7f) begin
      sk_age_reg <= sk_age_reg + 7'h01;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_ABSENT_NO_CS: assert property (
    !present_reg && state_reg != SECL_SAMPLE |-> !cs_reg)
    else $error("Chip select raised without an EEPROM");
  AST_PRESENT_LOADS: assert property (
    $rose(present_reg) |-> ##[1:45] cs_reg)
    else $error("Load did not start with EEPROM present");
  // The first rise of a frame is timed from chip select, not from a fall
  AST_SK_SLOW: assert property (
    cs_reg && slow_reg && $changed(sk_reg) && !(sk_reg && bit_reg == 5'h00)
      |-> sk_age_reg == 7'(`SECL_HALF_SLOW - 1))
    else $error("Slow serial clock half period wrong");
  AST_SK_FAST: assert property (
    !slow_reg && $fell(sk_reg) |-> sk_age_reg == 7'(`SECL_HALF_FAST - 1))
    else $error("Fast serial clock half period wrong");
  AST_DOUT_STABLE_HIGH: assert property (
    sk_reg && $past(sk_reg) |-> $stable(dout_reg))
    else $error("Serial out changed while clock high");
  AST_WE_ONLY_PRESENT: assert property (
    we_reg |-> present_reg && !cs_reg && $past(sk_reg))
    else $error("Word written outside a present load");
  // Done rises two ticks after the latch edge, so look back two ticks at the strap
  AST_WIDTH_STRAP: assert property (
    $rose(done_reg) && !present_reg
      |-> mode_reg == (IS_32B ? SECL_BUS_32 :
                       ($past(pins_sync[0], 2) ? SECL_BUS_16 : SECL_BUS_8)))
    else $error("Width strap decoded wrongly");
  AST_DONE_AFTER_LOAD: assert property (
    done_reg |-> !cs_reg && $stable(mode_reg) && $stable(present_reg))
    else $error("Done while loading or straps moved");

  COV_PRESENT_LOAD: cover property ($rose(done_reg) && present_reg);
  COV_ABSENT_16: cover property ($rose(done_reg) && mode_reg == SECL_BUS_16);
  COV_FAST_WORD: cover property (we_reg && !slow_reg);
endmodule : secl_loader

// ===== include/secl_regs.svh
`ifndef SECL_REGS_SVH
`define SECL_REGS_SVH
// Summary of operation
// - Strap high: EEPROM attached, serial load enabled
// - Strap low or open: no serial load
// - Drive serial out toward EEPROM data input
// - Speed 11: serial clock period 4 us
// - Speed 00: serial clock period 800 ns
// - EEPROM returns read data on serial in
// - No EEPROM, IS_32B clear: serial in selects 8/16-bit width

//----------------------------------------------------------------
// Timing
//----------------------------------------------------------------
`define SECL_MCLK_NS      50
`define SECL_SK_SLOW_NS   4000
`define SECL_SK_FAST_NS   800
`define SECL_HALF_SLOW    (`SECL_SK_SLOW_NS / (2 * `SECL_MCLK_NS))
`define SECL_HALF_FAST    (`SECL_SK_FAST_NS / (2 * `SECL_MCLK_NS))
`define SECL_SETTLE_CYC   3

//----------------------------------------------------------------
// Speed field encodings and read frame layout
//----------------------------------------------------------------
`define SECL_SPEED_SLOW   2'b11
`define SECL_SPEED_FAST   2'b00
`define SECL_CMD_BITS     9
`define SECL_READ_OP      3'h6
`define SECL_FIRST_DATA   10
`define SECL_LAST_BIT     25
`define SECL_WORD_BITS    16
`endif

// ===== include/secl_pkg.sv
package secl_pkg;
  typedef enum logic [1:0] {
    SECL_BUS_8  = 2'h0,
    SECL_BUS_16 = 2'h1,
    SECL_BUS_32 = 2'h2
  } secl_bus_e;

  typedef enum logic [1:0] {
    SECL_SAMPLE,
    SECL_GAP,
    SECL_SHIFT,
    SECL_DONE
  } secl_state_e;
endpackage : secl_pkg

// ===== rtl/secl_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser; only the second stage leaves the module
module secl_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Pins settle through two flops before any logic reads them
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule : secl_sync

// ===== test/secl_prom_model.sv
`timescale 1ns/1ns
//----------------------------------------------------------------
// Serial EEPROM model: 9-bit read command in, dummy zero, 16-bit word out
//----------------------------------------------------------------
module secl_prom_model (
  // Serial link from the loader
  input  wire logic       cs_i,
  input  wire logic       sk_i,
  input  wire logic       di_i,
  // Data back to the loader and last command seen
  output logic            do_o,
  output logic [8:0]      cmd_o
);
  logic [15:0] mem [0:63];
  int          bit_cnt;

  initial begin
    do_o    = 1'b0;
    cmd_o   = 9'h000;
    bit_cnt = 0;
  end

  // Bits move on the clock rise so they are settled long before the loader samples
  always @(posedge sk_i or negedge cs_i) begin
    if (!cs_i) begin
      bit_cnt <= 0;
      do_o    <= 1'b0; // Pin pull-down takes over once deselected
    end else begin
      if (bit_cnt < 9) cmd_o <= {cmd_o[7:0], di_i};
      // Dummy bit and command phase read as zero, then the word MSB first
      do_o    <= (bit_cnt >= 10 && bit_cnt <= 25) ? mem[cmd_o[5:0]][25 - bit_cnt] : 1'b0;
      bit_cnt <= bit_cnt + 1;
    end
  end
endmodule : secl_prom_model

// ===== test/tb_serial_eeprom_config_loader.sv
`timescale 1ns/1ns
module tb_serial_eeprom_config_loader;
  import secl_pkg::*;
  localparam int WORDS = 4;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        present_strap = 1'b0;
  logic [1:0]  speed_ctl = 2'h0;
  logic        width_strap = 1'b0;
  logic        present_now = 1'b0;
  logic        prom_do, sout, sk, cs, cfg_we, config_done, cs_seen;
  logic [8:0]  cmd;
  logic [15:0] cfg_word;
  logic [5:0]  cfg_addr;
  secl_bus_e   bus_mode;
  secl_bus_e   bus_mode_32;
  logic [30:0] exp_q [$];
  logic [31:0] seed = 32'h0000004f;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  time         last_rise = 0;
  time         exp_period = 0;

  // Pin is the EEPROM's output when one is fitted, else the width strap
  wire din = present_now ? prom_do : width_strap;

  always #25 mclk = ~mclk;

  secl_loader #(.WORDS(WORDS), .ADDR_W(6), .IS_32B(1'b0)) u_dut (
    .mclk_i(mclk), .rst_i(rst), .prom_present_strap_i(present_strap),
    .onchip_bus_speed_ctl_i(speed_ctl), .prom_serial_in_width_strap_i(din),
    .prom_serial_out_o(sout), .prom_serial_clock_o(sk), .prom_cs_o(cs),
    .cfg_word_o(cfg_word), .cfg_addr_o(cfg_addr), .cfg_we_o(cfg_we),
    .config_done_o(config_done), .bus_mode_o(bus_mode));

  // Second copy built as a 32-bit part; it only reports its bus mode
  secl_loader #(.WORDS(WORDS), .ADDR_W(6), .IS_32B(1'b1)) u_dut_32 (
    .mclk_i(mclk), .rst_i(rst), .prom_present_strap_i(present_strap),
    .onchip_bus_speed_ctl_i(speed_ctl), .prom_serial_in_width_strap_i(din),
    .prom_serial_out_o(), .prom_serial_clock_o(), .prom_cs_o(),
    .cfg_word_o(), .cfg_addr_o(), .cfg_we_o(),
    .config_done_o(), .bus_mode_o(bus_mode_32));

  secl_prom_model u_prom (.cs_i(cs), .sk_i(sk), .di_i(sout), .do_o(prom_do), .cmd_o(cmd));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic fail(input string msg);
    n_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : fail

  task automatic check_word(input logic [30:0] got, input logic [30:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("word got %h exp %h", got, exp));
  endtask : check_word

  task automatic check_time(input time got, input time exp);
    n_checks++;
    if (got !== exp) fail($sformatf("clock period got %0t exp %0t", got, exp));
  endtask : check_time

  task automatic check_flag(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("flag got %h exp %h", got, exp));
  endtask : check_flag

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Every write pulse retires the oldest expected word; done must still be low
  always @(posedge mclk) begin
    if (!rst && cfg_we) begin
      if (exp_q.size() == 0) fail("word with none expected");
      else check_word({cmd, cfg_addr, cfg_word}, exp_q.pop_front());
      check_flag({1'b0, config_done}, 2'h0);
    end
  end

  // Serial clock period, measured only between rises inside one frame
  always @(posedge cs) begin
    cs_seen   = 1'b1;
    last_rise = 0;
  end
  always @(posedge sk) begin
    if (last_rise != 0) check_time($time - last_rise, exp_period);
    last_rise = $time;
  end

  // Hang guard: ceiling well above the slowest full load
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      fail("timeout");
      summarize();
    end
  end

  // One start-up: reset, straps, then changes after the latch that must be ignored
  task automatic run(input logic present, input logic [1:0] speed, input logic width);
    int          i;
    int          n;
    logic [31:0] r;
    @(posedge mclk);
    rst           <= 1'b1;
    present_strap <= present;
    speed_ctl     <= speed;
    width_strap   <= width;
    present_now   <= present;
    cs_seen       = 1'b0;
    exp_period    = (speed == 2'h0) ? 800 : 4000;
    exp_q.delete();
    for (i = 0; i < WORDS; i++) begin
      r = xs();
      u_prom.mem[i] = r[15:0];
      if (present) exp_q.push_back({3'h6, i[5:0], i[5:0], r[15:0]});
    end
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (12) @(posedge mclk);
    present_strap <= ~present;
    speed_ctl     <= ~speed;
    width_strap   <= ~width;
    n = 0;
    while (config_done !== 1'b1 && n < 30000) begin
      @(posedge mclk);
      n++;
    end
    repeat (2) @(posedge mclk);
    check_flag({1'b0, config_done}, 2'h1);
    check_flag({1'b0, cs_seen}, {1'b0, present});
    check_word({25'h0, 6'(exp_q.size())}, 31'h0);
    if (!present) check_flag(bus_mode, width ? SECL_BUS_16 : SECL_BUS_8);
    if (!present) check_flag(bus_mode_32, SECL_BUS_32);
  endtask : run

  initial begin
    repeat (5) @(posedge mclk);
    run(1'b1, 2'h3, 1'b0);
    run(1'b1, 2'h0, 1'b1);
    run(1'b1, 2'h1, 1'b0);
    run(1'b0, 2'h0, 1'b0);
    run(1'b0, 2'h3, 1'b1);
    summarize();
  end
endmodule : tb_serial_eeprom_config_loader
